// ==== src/gpxp_pkg.sv ====
// Purpose: Shared constants and types for the eight-line expander port
// Assumes: mclk at 100 MHz, SPI mode 0 style framing
// Notes:   Register indices follow the command byte address field
package gpxp_pkg;
	localparam int          GPXP_LINES      = 8;
	localparam int          GPXP_ADDR_W     = 6;
	localparam int          GPXP_CLK_NS     = 10;
	// Filter acceptance window in ns; qualify time sits inside it
	localparam int          GPXP_FLT_MIN_NS = 225;
	localparam int          GPXP_FLT_MAX_NS = 1075;
	localparam int          GPXP_FLT_NS     = 650;
	localparam int          GPXP_FLT_CYC    = GPXP_FLT_NS / GPXP_CLK_NS;
	localparam int          GPXP_CNT_W      = 7;

	localparam logic [5:0]  ADDR_PIN_STATE  = 6'h00;
	localparam logic [5:0]  ADDR_OUT_LEVEL  = 6'h01;
	localparam logic [5:0]  ADDR_IN_INVERT  = 6'h02;
	localparam logic [5:0]  ADDR_DIRECTION  = 6'h03;
	localparam logic [5:0]  ADDR_PULLUP     = 6'h04;
	localparam logic [5:0]  ADDR_IRQ_EN     = 6'h05;
	localparam logic [5:0]  ADDR_OUT_FLOAT  = 6'h06;
	localparam logic [5:0]  ADDR_IRQ_PEND   = 6'h07;
	localparam logic [5:0]  ADDR_RISE_EN    = 6'h08;
	localparam logic [5:0]  ADDR_FALL_EN    = 6'h09;
	localparam logic [5:0]  ADDR_FILTER_EN  = 6'h0A;

	localparam logic [7:0]  RST_OUT_LEVEL   = 8'hFF;
	localparam logic [7:0]  RST_DIRECTION   = 8'hFF;
	localparam logic [7:0]  RST_FILTER_EN   = 8'hFF;
	localparam logic [7:0]  RST_ZERO        = 8'h00;

	localparam int          CMD_RW_BIT      = 7;
	localparam logic [2:0]  BIT_LAST        = 3'h7;

	typedef struct packed {
		logic       rd;
		logic [5:0] addr;
	} gpxp_cmd_s;

	typedef enum logic [1:0] {GPXP_CMD, GPXP_DATA, GPXP_DONE} gpxp_state_e;
endpackage

// ==== src/gpxp_port.sv ====
// Purpose: Eight-line GPIO expander port core behind an SPI slave
// Assumes: SPI pins are slow against mclk and are oversampled
// Notes:   Mode 0: sample on rising sclk, shift out on falling sclk
//
// How it works
// RULE1: Pin-state view returns input levels, inverted where invert bit set.
// RULE2: Output lines read back the output-level register in pin-state view.
// RULE3: Writes to the pin-state view are ignored entirely.
// RULE4: Bit seven maps to line seven, bit zero to line zero.
// RULE5: Outputs drive output-level bits; reads return last written value.
// RULE6: Invert bit one complements the pin, zero passes it unchanged.
// RULE7: Direction zero is output, one is input; reset makes all inputs.
// RULE8: Pull-up bit one enables pull-up, zero disables; reset all off. The code turns the pull-up on for input lines only.
// RULE9: Output lines never raise interrupts.
// RULE10: Float bit one puts the output in high impedance.
// RULE11: Pending register shows which input lines raised an interrupt.
// RULE12: Rise one, fall zero: only rising edges interrupt.
// RULE13: Rise zero, fall one: only falling edges interrupt.
// RULE14: Rise equals fall: either edge interrupts.
// RULE15: Both selects zero: pending clears when input returns to read level.
// RULE16: Any pin-state read clears pending interrupts.
// RULE17: Filter ignores pulses under 225ns, accepts changes beyond 1075ns.
// RULE18: Filter bits reset to all ones; zero bypasses the filter.
// RULE19: Interrupt enable zero, the reset default, blocks that line.
// RULE20: Host sends command byte: bit 7 read, bits 6:1 address.
// RULE21: Registers sit at addresses 0x00 to 0x0A in fixed order.
// RULE22: Output level resets to 0xFF, output float to 0x00.
// RULE23: Open-drain interrupt pulls low while any pending bit is set.
// RULE24: Filter is a fixed qualify counter inside the window.
`timescale 1ns/1ps
module gpxp_port
	import gpxp_pkg::*;
#(
	parameter int LINES = GPXP_LINES
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             sdi,
	output logic                  sdo,
	output logic                  sdo_oe_n,
	input  wire logic [LINES-1:0] io_in,
	output logic [LINES-1:0]      io_out,
	output logic [LINES-1:0]      io_oe_n,
	output logic [LINES-1:0]      pullup_on,
	output logic                  irq_out,
	output logic                  irq_oe_n
);
	logic [2:0]       sclk_sync_reg;
	logic [2:0]       cs_sync_reg;
	logic [1:0]       sdi_sync_reg;
	logic [LINES-1:0] io_meta_reg;
	logic [LINES-1:0] io_sync_reg;

	logic [LINES-1:0] output_level_reg;
	logic [LINES-1:0] input_invert_reg;
	logic [LINES-1:0] line_direction_reg;
	logic [LINES-1:0] pullup_enable_reg;
	logic [LINES-1:0] irq_enable_reg;
	logic [LINES-1:0] output_float_reg;
	logic [LINES-1:0] irq_pending_reg;
	logic [LINES-1:0] rise_irq_enable_reg;
	logic [LINES-1:0] fall_irq_enable_reg;
	logic [LINES-1:0] glitch_filter_enable_reg;

	logic [LINES-1:0] filt_level_reg;
	logic [LINES-1:0] filt_prev_reg;
	logic [LINES-1:0] read_level_reg;
	logic [GPXP_CNT_W-1:0] filt_cnt_reg [LINES];

	gpxp_state_e      state_reg;
	logic [2:0]       bit_cnt_reg;
	logic [7:0]       shift_reg;
	logic [7:0]       tx_reg;
	gpxp_cmd_s        cmd_reg;

	logic             sclk_rise;
	logic             sclk_fall;
	logic             cs_act;
	logic [7:0]       rx_byte;
	logic             byte_done;
	logic             wr_strobe;
	logic             pin_read;
	logic [LINES-1:0] pin_view;
	logic [LINES-1:0] edge_hit;
	logic [LINES-1:0] back_clear;
	logic [7:0]       rd_data;

	// Select read data for a register index
	function automatic logic [7:0] reg_read(input logic [5:0] a);
		case (a)
			ADDR_PIN_STATE: reg_read = pin_view;
			ADDR_OUT_LEVEL: reg_read = output_level_reg;
			ADDR_IN_INVERT: reg_read = input_invert_reg;
			ADDR_DIRECTION: reg_read = line_direction_reg;
			ADDR_PULLUP:    reg_read = pullup_enable_reg;
			ADDR_IRQ_EN:    reg_read = irq_enable_reg;
			ADDR_OUT_FLOAT: reg_read = output_float_reg;
			ADDR_IRQ_PEND:  reg_read = irq_pending_reg;
			ADDR_RISE_EN:   reg_read = rise_irq_enable_reg;
			ADDR_FALL_EN:   reg_read = fall_irq_enable_reg;
			ADDR_FILTER_EN: reg_read = glitch_filter_enable_reg;
			default:        reg_read = RST_ZERO;
		endcase
	endfunction

	// Pins come from outside: two flops before any logic
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg   <= 3'h7;
			sdi_sync_reg  <= 2'h0;
			io_meta_reg   <= '0;
			io_sync_reg   <= '0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
			cs_sync_reg   <= {cs_sync_reg[1:0], cs_n};
			sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
			io_meta_reg   <= io_in;
			io_sync_reg   <= io_meta_reg;
		end
	end

	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign cs_act    = ~cs_sync_reg[1];
	assign rx_byte   = {shift_reg[6:0], sdi_sync_reg[1]};
	assign byte_done = cs_act & sclk_rise & (bit_cnt_reg == BIT_LAST);
	// Pin-state view: inputs with polarity, outputs read back latch
	assign pin_view  = (line_direction_reg & (io_sync_reg ^ input_invert_reg))
		| (~line_direction_reg & output_level_reg); // RULE1 RULE2 RULE6 RULE4
	assign wr_strobe = byte_done & (state_reg == GPXP_DATA) & ~cmd_reg.rd;
	assign pin_read  = byte_done & (state_reg == GPXP_CMD)
		& rx_byte[CMD_RW_BIT] & (rx_byte[6:1] == ADDR_PIN_STATE); // RULE16
	assign rd_data   = reg_read(rx_byte[6:1]);

	// Command byte then one data byte per frame
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg   <= GPXP_CMD;
			bit_cnt_reg <= 3'h0;
			shift_reg   <= 8'h00;
			cmd_reg     <= '0;
		end else if (!cs_act) begin
			state_reg   <= GPXP_CMD;
			bit_cnt_reg <= 3'h0;
		end else if (sclk_rise) begin
			shift_reg   <= rx_byte;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == BIT_LAST) begin
				case (state_reg)
					GPXP_CMD: begin
						cmd_reg.rd   <= rx_byte[CMD_RW_BIT]; // RULE20
						cmd_reg.addr <= rx_byte[6:1];
						state_reg    <= GPXP_DATA;
					end
					GPXP_DATA: state_reg <= GPXP_DONE;
					GPXP_DONE: state_reg <= GPXP_DONE;
					default:   state_reg <= GPXP_CMD;
				endcase
			end
		end
	end

	// Read data is captured at command end, shifted out on falling sclk
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_reg   <= 8'h00;
			sdo      <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else begin
			sdo_oe_n <= ~(cs_act & (state_reg == GPXP_DATA) & cmd_reg.rd);
			if (pin_read || (byte_done && state_reg == GPXP_CMD)) begin
				tx_reg <= rd_data;
			end else if (sclk_fall && state_reg == GPXP_DATA) begin
				sdo    <= tx_reg[7];
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
		end
	end

	// Register writes; pin-state and pending indices fall through
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			output_level_reg         <= RST_OUT_LEVEL; // RULE22
			input_invert_reg         <= RST_ZERO;
			line_direction_reg       <= RST_DIRECTION; // RULE7
			pullup_enable_reg        <= RST_ZERO; // RULE8
			irq_enable_reg           <= RST_ZERO; // RULE19
			output_float_reg         <= RST_ZERO; // RULE22
			rise_irq_enable_reg      <= RST_ZERO;
			fall_irq_enable_reg      <= RST_ZERO;
			glitch_filter_enable_reg <= RST_FILTER_EN; // RULE18
		end else if (wr_strobe) begin
			case (cmd_reg.addr) // RULE21
				ADDR_OUT_LEVEL: output_level_reg    <= rx_byte;
				ADDR_IN_INVERT: input_invert_reg    <= rx_byte;
				ADDR_DIRECTION: line_direction_reg  <= rx_byte;
				ADDR_PULLUP:    pullup_enable_reg   <= rx_byte;
				ADDR_IRQ_EN:    irq_enable_reg      <= rx_byte;
				ADDR_OUT_FLOAT: output_float_reg    <= rx_byte;
				ADDR_RISE_EN:   rise_irq_enable_reg <= rx_byte;
				ADDR_FALL_EN:   fall_irq_enable_reg <= rx_byte;
				ADDR_FILTER_EN: glitch_filter_enable_reg <= rx_byte;
				default: ; // RULE3
			endcase
		end
	end

	// Qualify counter: a change must hold for GPXP_FLT_CYC cycles
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			filt_level_reg <= '0;
			filt_prev_reg  <= '0;
			for (int i = 0; i < LINES; i++) begin
				filt_cnt_reg[i] <= '0;
			end
		end else begin
			filt_prev_reg <= filt_level_reg;
			for (int i = 0; i < LINES; i++) begin
				if (!glitch_filter_enable_reg[i]) begin
					filt_level_reg[i] <= io_sync_reg[i]; // RULE18
					filt_cnt_reg[i]   <= '0;
				end else if (io_sync_reg[i] == filt_level_reg[i]) begin
					filt_cnt_reg[i]   <= '0;
				end else if (filt_cnt_reg[i] ==
					GPXP_CNT_W'(GPXP_FLT_CYC - 1)) begin
					filt_level_reg[i] <= io_sync_reg[i]; // RULE17 RULE24
					filt_cnt_reg[i]   <= '0;
				end else begin
					filt_cnt_reg[i]   <= filt_cnt_reg[i] + GPXP_CNT_W'(1);
				end
			end
		end
	end

	// Edge select: equal bits mean either edge
	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			if (rise_irq_enable_reg[i] == fall_irq_enable_reg[i]) begin
				edge_hit[i] = filt_level_reg[i] ^ filt_prev_reg[i]; // RULE14
			end else if (rise_irq_enable_reg[i]) begin
				edge_hit[i] = filt_level_reg[i] & ~filt_prev_reg[i]; // RULE12
			end else begin
				edge_hit[i] = ~filt_level_reg[i] & filt_prev_reg[i]; // RULE13
			end
		end
	end

	assign back_clear = ~rise_irq_enable_reg & ~fall_irq_enable_reg
		& ~(filt_level_reg ^ read_level_reg); // RULE15

	// Input level latched at each pin-state read for return-to-level clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			read_level_reg <= '0;
		end else if (pin_read) begin
			read_level_reg <= filt_level_reg;
		end
	end

	// Set wins over any clear in the same cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_pending_reg <= RST_ZERO;
		end else begin
			irq_pending_reg <= (edge_hit & irq_enable_reg & line_direction_reg)
				| (irq_pending_reg & ~back_clear
				& ~{LINES{pin_read}}); // RULE9 RULE11 RULE16 RULE19
		end
	end

	// Pin drive; open-drain interrupt output
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			io_out    <= RST_OUT_LEVEL;
			io_oe_n   <= '1;
			pullup_on <= '0;
			irq_out   <= 1'b0;
			irq_oe_n  <= 1'b1;
		end else begin
			io_out    <= output_level_reg; // RULE5
			io_oe_n   <= line_direction_reg | output_float_reg; // RULE7 RULE10
			pullup_on <= pullup_enable_reg & line_direction_reg; // RULE8
			irq_out   <= 1'b0;
			irq_oe_n  <= ~|irq_pending_reg; // RULE23
		end
	end
endmodule

// ==== sim/gpxp_port_asserts.sv ====
// Purpose: Port-level checks for the expander port core
// Assumes: One clock domain, mclk; reset_n async active low
// Notes:   qcnt counts quiet cycles on the pins to bound irq causes
`timescale 1ns/1ps
module gpxp_port_asserts
	import gpxp_pkg::*;
#(
	parameter int LINES = GPXP_LINES
) (
	input wire logic             mclk,
	input wire logic             reset_n,
	input wire logic             sclk,
	input wire logic             cs_n,
	input wire logic             sdi,
	input wire logic             sdo,
	input wire logic             sdo_oe_n,
	input wire logic [LINES-1:0] io_in,
	input wire logic [LINES-1:0] io_out,
	input wire logic [LINES-1:0] io_oe_n,
	input wire logic [LINES-1:0] pullup_on,
	input wire logic             irq_out,
	input wire logic             irq_oe_n
);
	logic [LINES-1:0] in_d;
	logic [7:0]       qcnt;

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// Saturates so a long quiet spell never wraps into a false cause
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			in_d <= '0;
			qcnt <= 8'hFF;
		end else begin
			in_d <= io_in;
			if (io_in != in_d) qcnt <= 8'h00;
			else if (qcnt != 8'hFF) qcnt <= qcnt + 8'h01;
		end
	end

	irq_data_low_a: assert property (irq_out == 1'b0)
		else $error("irq data pin not low");
	rst_values_a: assert property ($rose(reset_n) |->
		io_oe_n == '1 && io_out == '1 && pullup_on == '0 && irq_oe_n)
		else $error("outputs not at reset values");
	idle_hold_a: assert property (cs_n [*8] |-> $stable(io_oe_n) &&
		$stable(io_out) && $stable(pullup_on))
		else $error("pin config changed outside a frame");
	pull_drive_a: assert property ((pullup_on & ~io_oe_n) == '0)
		else $error("pull-up on a driven line");
	irq_cause_a: assert property ($fell(irq_oe_n) |-> qcnt <= 8'h5A)
		else $error("interrupt without a pin change");
	irq_clear_a: assert property ($rose(irq_oe_n) |->
		!cs_n || qcnt <= 8'h5A)
		else $error("interrupt released without cause");
	sdo_frame_a: assert property ($fell(sdo_oe_n) |-> !cs_n)
		else $error("sdo driven outside a frame");
	sdo_idle_a: assert property (cs_n [*8] |-> sdo_oe_n)
		else $error("sdo still driven after frame");

	cover property ($fell(irq_oe_n));
	cover property ($fell(sdo_oe_n));
	cover property ($changed(io_oe_n));
endmodule

bind gpxp_port gpxp_port_asserts #(.LINES(LINES)) gpxp_port_asserts_i (
	.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
	.sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .io_in(io_in),
	.io_out(io_out), .io_oe_n(io_oe_n), .pullup_on(pullup_on),
	.irq_out(irq_out), .irq_oe_n(irq_oe_n)
);

// ==== sim/gpxp_host.sv ====
// Purpose: SPI master model that reads and writes port registers
// Assumes: Mode 0, sclk low for ten mclk and high for five mclk per bit
// Notes:   Slow phases suit the oversampling slave
`timescale 1ns/1ps
module gpxp_host (
	input  wire logic mclk,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	task automatic xfer(input logic rd, input logic [5:0] adr,
		input logic [7:0] wd, output logic [7:0] q);
		logic [15:0] sh;
		sh = {rd, adr, 1'b0, wd};
		q  = 8'h00;
		@(posedge mclk) cs_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			repeat (5) @(posedge mclk);
			sdi <= sh[15-i];
			repeat (5) @(posedge mclk);
			sclk <= 1'b1;
			if (i >= 8) q = {q[6:0], sdo};
			repeat (5) @(posedge mclk);
			sclk <= 1'b0;
		end
		repeat (5) @(posedge mclk);
		cs_n <= 1'b1;
		// Released line shows a changed level, not the last bit
		sdi  <= ~sdi;
		repeat (6) @(posedge mclk);
	endtask
endmodule

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the expander port
// Assumes: Host model drives SPI, bench drives the pins
// Notes:   Filter kept at full length; run stays short
`timescale 1ns/1ps
module tb;
	import gpxp_pkg::*;
	typedef struct packed {
		logic [5:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} gpxp_row_s;
	logic       mclk, reset_n, sclk, cs_n, sdi, sdo, sdo_oe_n;
	logic       irq_out, irq_oe_n;
	logic [7:0] io_in, io_out, io_oe_n, pullup_on, ext, q;
	int         mismatches = 0;
	int         compares = 0;
	int         cyc = 0;
	gpxp_row_s  rows [11] = '{'{6'h01, 8'hA5, 8'hA5},
		'{6'h02, 8'h3C, 8'h3C}, '{6'h03, 8'hF0, 8'hF0},
		'{6'h04, 8'h33, 8'h33}, '{6'h05, 8'h81, 8'h81},
		'{6'h06, 8'h18, 8'h18}, '{6'h08, 8'h42, 8'h42},
		'{6'h09, 8'h24, 8'h24}, '{6'h0A, 8'h00, 8'h00},
		'{6'h07, 8'hFF, 8'h00}, '{6'h0B, 8'h55, 8'h00}};
	logic [7:0] rst_v [11] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
	logic [1:0] md [4] = '{2'b10, 2'b01, 2'b11, 2'b00};

	// Driven lines show the device level, others the outside driver
	assign io_in = (io_out & ~io_oe_n) | (ext & io_oe_n);

	gpxp_host gpxp_host_i (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo));
	gpxp_port #(.LINES(8)) gpxp_port_i (.mclk(mclk), .reset_n(reset_n),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.sdo_oe_n(sdo_oe_n), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n), .pullup_on(pullup_on), .irq_out(irq_out),
		.irq_oe_n(irq_oe_n));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		gpxp_host_i.xfer(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		gpxp_host_i.xfer(1'b1, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic clr();
		gpxp_host_i.xfer(1'b1, 6'h00, 8'h00, q);
	endtask
	task automatic pin_edge(input logic [7:0] x, input int n);
		@(posedge mclk) ext <= ext ^ x;
		repeat (n) @(posedge mclk);
	endtask
	task final_report();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		reset_n = 1'b0;
		ext     = 8'h00;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (6) @(posedge mclk);
		chk(io_oe_n, 8'hFF);
		chk(io_out, 8'hFF);
		chk(pullup_on, 8'h00);
		chk({7'h00, sdo_oe_n}, 8'h01);
		for (int a = 0; a < 11; a++)
			rd(6'(a), rst_v[a]);
		for (int i = 0; i < 11; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		@(posedge mclk) ext <= 8'h1E;
		chk(io_oe_n, 8'hF8);
		chk(io_out, 8'hA5);
		chk(pullup_on, 8'h30);
		rd(6'h00, 8'h25);
		wr(6'h00, 8'h00);
		rd(6'h00, 8'h25);
		rd(6'h01, 8'hA5);
		// Line 6 has no enable and line 0 is an output: both stay quiet
		for (int k = 0; k < 4; k++) begin
			wr(6'h08, {md[k][1], 7'h00});
			wr(6'h09, {md[k][0], 7'h00});
			clr();
			wr(6'h01, k[0] ? 8'hA4 : 8'hA5);
			pin_edge(8'hC0, 20);
			rd(6'h07, {md[k][1] | ~md[k][0], 7'h00});
			chk({7'h00, irq_oe_n}, {7'h00, md[k] == 2'b01});
			if (md[k] == 2'b00) begin
				pin_edge(8'hC0, 20);
				rd(6'h07, 8'h00);
			end else begin
				clr();
				rd(6'h07, 8'h00);
				pin_edge(8'hC0, 20);
				rd(6'h07, {md[k][0] | ~md[k][1], 7'h00});
				clr();
			end
		end
		wr(6'h0A, 8'h80);
		wr(6'h08, 8'h80);
		wr(6'h09, 8'h80);
		clr();
		pin_edge(8'h80, 20);
		pin_edge(8'h80, 120);
		rd(6'h07, 8'h00);
		pin_edge(8'h80, 110);
		rd(6'h07, 8'h80);
		// A write aimed at the pin-state view must not clear pending
		wr(6'h00, 8'h00);
		rd(6'h07, 8'h80);
		@(posedge mclk) reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		chk(io_oe_n, 8'hFF);
		chk({7'h00, irq_oe_n}, 8'h01);
		reset_n <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(6'h01, 8'hFF);
		final_report();
	end
endmodule
